/* File: inc/fpm_cfg.svh */
// constants for the flash parallel programming mode mux
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH
`define FPM_MODE_PROG 3'h7
`define FPM_ADDR_W 22
`define FPM_DATA_W 16
`define FPM_SYNC_RST 2'h0
`define FPM_SYNC_DONE 2'h2
`endif

/* File: inc/fpm_pkg.sv */
// types for the flash parallel programming mode mux
package fpm_pkg;
  typedef enum logic [1:0] {
    FPM_RESET = 2'h0,
    FPM_NORMAL = 2'h1,
    FPM_PROG = 2'h2
  } fpm_mode_e;
endpackage : fpm_pkg

/* File: testbench/flash_parallel_program_mode_bench.sv */
// self-checking bench for the flash programming mode mux
`timescale 1ns/100ps
module flash_parallel_program_mode_bench;
  logic clk, rst, rd, wr, bn, cwe, coe, cce, rb_n, p_ce, p_oe, p_we, p_wid;
  logic p_rst, dq_oe, rb_pin, rb_oe, crdy, halt, we_n, oe_n, ce_n, wid_n;
  logic frst_n;
  logic [2:0] mode;
  logic [21:0] addr, caddr, p_a, f_addr;
  logic [15:0] wdata, cwdata, frd, p_dq, dq_out, crdata, f_wdata;
  int failures, check_count, cycles;
  fpm_prog_model i_fpm_prog_model (.clk(clk), .rd(rd), .wr(wr), .byte_n(bn),
    .addr(addr), .wdata(wdata), .ce_n(p_ce), .oe_n(p_oe), .we_n(p_we),
    .wid_n(p_wid), .frst_n(p_rst), .a(p_a), .dq(p_dq));
  fpm_top i_fpm_top (.clk(clk), .rst(rst), .mode_select_pins(mode),
    .pin_write_strobe_n(p_we), .pin_output_strobe_n(p_oe),
    .pin_chip_select_n(p_ce), .pin_width_select_n(p_wid),
    .pin_flash_reset_n(p_rst), .pin_addr(p_a), .pin_dq_in(p_dq),
    .pin_dq_out(dq_out), .pin_dq_oe(dq_oe), .pin_ready_busy_n(rb_pin),
    .pin_ready_busy_oe(rb_oe), .cpu_we_n(cwe), .cpu_oe_n(coe),
    .cpu_ce_n(cce), .cpu_addr(caddr), .cpu_wdata(cwdata),
    .cpu_rdata(crdata), .cpu_ready(crdy), .cpu_halt(halt),
    .write_strobe_n(we_n), .output_strobe_n(oe_n), .chip_select_n(ce_n),
    .width_select_n(wid_n), .flash_reset_n(frst_n), .flash_addr(f_addr),
    .flash_wdata(f_wdata), .flash_rdata(frd), .ready_busy_n(rb_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic boot(input logic [2:0] m);
    mode = m;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
  endtask : boot
  task automatic test_prog;
    boot(3'h7);
    chk(halt, 1'b1);
    chk(rb_oe, 1'b1);
    cwe = 1'b0;
    cce = 1'b0;
    addr = 22'h012345;
    frd = 16'hA55A;
    rb_n = 1'b0;
    rd = 1'b1;
    repeat (4) @(negedge clk);
    chk(ce_n, 1'b0);
    chk(oe_n, 1'b0);
    chk(we_n, 1'b1);
    chk(f_addr, 22'h112345);
    chk(dq_oe, 1'b1);
    chk(dq_out, 16'hA55A);
    chk(rb_pin, 1'b0);
    chk(crdy, 1'b0);
    chk(crdata, 16'h0000);
    chk(frst_n, 1'b1);
    chk(wid_n, 1'b1);
    rd = 1'b0;
    wr = 1'b1;
    bn = 1'b0;
    wdata = 16'h3CC3;
    rb_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(wid_n, 1'b0);
    chk(oe_n, 1'b1);
    chk(we_n, 1'b0);
    chk(f_wdata, 16'h3CC3);
    chk(dq_oe, 1'b0);
    chk(rb_pin, 1'b1);
    wr = 1'b0;
    cwe = 1'b1;
    cce = 1'b1;
  endtask : test_prog
  task automatic test_norm;
    bn = 1'b0;
    boot(3'h3);
    chk(halt, 1'b0);
    caddr = 22'h2A0F0F;
    cwdata = 16'h0F0F;
    cce = 1'b0;
    cwe = 1'b0;
    rb_n = 1'b0;
    rd = 1'b1;
    repeat (3) @(negedge clk);
    chk(we_n, 1'b0);
    chk(oe_n, 1'b1);
    chk(ce_n, 1'b0);
    chk(f_addr, 22'h2A0F0F);
    chk(f_wdata, 16'h0F0F);
    chk(wid_n, 1'b1);
    chk(crdy, 1'b0);
    chk(dq_oe, 1'b0);
    chk(rb_oe, 1'b0);
    cwe = 1'b1;
    coe = 1'b0;
    frd = 16'h5AA5;
    rb_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(oe_n, 1'b0);
    chk(crdata, 16'h5AA5);
    chk(crdy, 1'b1);
    chk(dq_oe, 1'b0);
  endtask : test_norm
  task automatic tally_and_finish;
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // ceiling well above the few dozen cycles the two scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst, bn, cwe, coe, cce, rb_n} = 6'h3F;
    {rd, wr} = 2'h0;
    {mode, addr, caddr, wdata, cwdata, frd} = '0;
    @(negedge clk);
    test_prog();
    test_norm();
    tally_and_finish();
  end
endmodule : flash_parallel_program_mode_bench

/* File: testbench/fpm_prog_model.sv */
// parallel flash programmer model driving the device pins
`timescale 1ns/100ps
module fpm_prog_model (
  input wire logic clk, // clock
  input wire logic rd, // read request
  input wire logic wr, // write request
  input wire logic byte_n, // width request
  input wire logic [21:0] addr, // word address
  input wire logic [15:0] wdata, // write data
  output logic ce_n, // chip select
  output logic oe_n, // output strobe
  output logic we_n, // write strobe
  output logic wid_n, // width select
  output logic frst_n, // flash reset
  output logic [21:0] a, // address pins
  output logic [15:0] dq // data pins
);
  logic flip = 1'b0;
  always @(posedge clk) flip <= ~flip;
  // the programmer drives the array only through this mode
  assign ce_n = ~(rd | wr);
  assign oe_n = ~rd;
  assign we_n = ~wr;
  assign wid_n = byte_n;
  assign frst_n = 1'b1;
  assign a = addr | 22'h100000;
  // released bus toggles so a stale value never passes for data
  assign dq = wr ? wdata : {16{flip}};
endmodule : fpm_prog_model

/* File: verilog/fpm_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module fpm_sync #(
  parameter int W = 1
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic [W-1:0] d, // async input
  output logic [W-1:0] q // synchronised
);
  logic [W-1:0] meta_reg;
  initial begin
    if (W < 1) $error("fpm_sync width");
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : fpm_sync

/* File: verilog/fpm_top.sv */
// flash interface mux: cpu mode or parallel programming mode
`timescale 1ns/100ps
`include "fpm_cfg.svh"
module fpm_top #(
  parameter int AW = `FPM_ADDR_W,
  parameter int DW = `FPM_DATA_W
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset, high
  input wire logic [2:0] mode_select_pins, // mode pins
  input wire logic pin_write_strobe_n, // programmer write strobe
  input wire logic pin_output_strobe_n, // programmer output strobe
  input wire logic pin_chip_select_n, // programmer chip select
  input wire logic pin_width_select_n, // programmer width select
  input wire logic pin_flash_reset_n, // programmer flash reset
  input wire logic [AW-1:0] pin_addr, // programmer address
  input wire logic [DW-1:0] pin_dq_in, // data pins in
  output logic [DW-1:0] pin_dq_out, // data pins out
  output logic pin_dq_oe, // data pins drive enable
  output logic pin_ready_busy_n, // ready/busy to pin
  output logic pin_ready_busy_oe, // ready/busy drive enable
  input wire logic cpu_we_n, // cpu write strobe
  input wire logic cpu_oe_n, // cpu output strobe
  input wire logic cpu_ce_n, // cpu chip select
  input wire logic [AW-1:0] cpu_addr, // cpu address
  input wire logic [DW-1:0] cpu_wdata, // cpu write data
  output logic [DW-1:0] cpu_rdata, // cpu read data
  output logic cpu_ready, // flash ready status for cpu
  output logic cpu_halt, // processor halted
  output logic write_strobe_n, // to flash array
  output logic output_strobe_n, // to flash array
  output logic chip_select_n, // to flash array
  output logic width_select_n, // to flash array
  output logic flash_reset_n, // to flash array
  output logic [AW-1:0] flash_addr, // to flash array
  output logic [DW-1:0] flash_wdata, // to flash array
  input wire logic [DW-1:0] flash_rdata, // from flash array
  input wire logic ready_busy_n // from flash array
);
  initial begin
    if (AW < 21 || DW < 1) $error("fpm_top parameters");
  end
  ////////////////////////////////////////////////////////////////////////
  localparam int PW = 5 + AW + DW;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s;
  logic [2:0] mode_s;
  logic strap_seen_reg;
  fpm_pkg::fpm_mode_e mode_reg;
  logic prog;
  assign pin_raw = {pin_write_strobe_n, pin_output_strobe_n,
    pin_chip_select_n, pin_width_select_n, pin_flash_reset_n,
    pin_addr, pin_dq_in};
  fpm_sync #(.W(PW)) u_sync_pins (
    .clk(clk),
    .rst(rst),
    .d(pin_raw),
    .q(pin_s)
  );
  fpm_sync #(.W(3)) u_sync_mode (
    .clk(clk),
    .rst(rst),
    .d(mode_select_pins),
    .q(mode_s)
  );
  // strap is caught once after release; synchroniser is clean by then
  logic [1:0] wait_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg <= `FPM_SYNC_RST;
      strap_seen_reg <= 1'b0;
      mode_reg <= fpm_pkg::FPM_RESET;
    end else if (!strap_seen_reg) begin
      wait_reg <= wait_reg + 2'h1;
      if (wait_reg == `FPM_SYNC_DONE) begin
        strap_seen_reg <= 1'b1;
        mode_reg <= (mode_s == `FPM_MODE_PROG) ?
          fpm_pkg::FPM_PROG : fpm_pkg::FPM_NORMAL;
      end
    end
  end
  assign prog = (mode_reg == fpm_pkg::FPM_PROG);
  // programmer read: output strobe and chip select both low
  function automatic logic pin_read_req(input logic [PW-1:0] p);
    return !p[PW-2] && !p[PW-3];
  endfunction : pin_read_req
  ////////////////////////////////////////////////////////////////////////
  // flash side; cpu stays halted until the strap is known
  logic [DW-1:0] p_dq;
  logic [AW-1:0] p_addr;
  assign p_dq = pin_s[DW-1:0];
  assign p_addr = pin_s[DW+AW-1:DW];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
      chip_select_n <= 1'b1;
      width_select_n <= 1'b1;
      flash_reset_n <= 1'b0;
      flash_addr <= '0;
      flash_wdata <= '0;
      cpu_halt <= 1'b1;
    end else if (prog) begin
      cpu_halt <= 1'b1;
      write_strobe_n <= pin_s[PW-1];
      output_strobe_n <= pin_s[PW-2];
      chip_select_n <= pin_s[PW-3];
      width_select_n <= pin_s[PW-4];
      flash_reset_n <= pin_s[PW-5];
      flash_addr <= p_addr;
      flash_wdata <= p_dq;
    end else if (mode_reg == fpm_pkg::FPM_NORMAL) begin
      cpu_halt <= 1'b0;
      write_strobe_n <= cpu_we_n;
      output_strobe_n <= cpu_oe_n;
      chip_select_n <= cpu_ce_n;
      width_select_n <= 1'b1;
      flash_reset_n <= 1'b1;
      flash_addr <= cpu_addr;
      flash_wdata <= cpu_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // pin outputs; data driven only on a programmer read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_dq_out <= '0;
      pin_dq_oe <= 1'b0;
      pin_ready_busy_n <= 1'b0;
      pin_ready_busy_oe <= 1'b0;
    end else begin
      pin_dq_out <= flash_rdata;
      pin_dq_oe <= prog && pin_read_req(pin_s);
      pin_ready_busy_n <= ready_busy_n;
      pin_ready_busy_oe <= prog;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_rdata <= '0;
      cpu_ready <= 1'b0;
    end else begin
      cpu_rdata <= prog ? '0 : flash_rdata;
      cpu_ready <= prog ? 1'b0 : ready_busy_n;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  AST_HALT_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> cpu_halt)
    else $error("cpu not halted");
  AST_HALT_NORMAL: assert property (
    @(posedge clk) disable iff (rst)
    (mode_reg == fpm_pkg::FPM_NORMAL) |=> !cpu_halt)
    else $error("cpu halted in cpu mode");
  AST_WIDTH_NORMAL: assert property (
    @(posedge clk) disable iff (rst)
    $past(mode_reg == fpm_pkg::FPM_NORMAL) |-> width_select_n)
    else $error("width select low in cpu mode");
  AST_WE_NORMAL: assert property (
    @(posedge clk) disable iff (rst)
    (mode_reg == fpm_pkg::FPM_NORMAL) |=> write_strobe_n == $past(cpu_we_n))
    else $error("write strobe not from cpu");
  AST_OE_NORMAL: assert property (
    @(posedge clk) disable iff (rst)
    (mode_reg == fpm_pkg::FPM_NORMAL) |=> output_strobe_n == $past(cpu_oe_n))
    else $error("output strobe not from cpu");
  AST_CE_NORMAL: assert property (
    @(posedge clk) disable iff (rst)
    (mode_reg == fpm_pkg::FPM_NORMAL) |=> chip_select_n == $past(cpu_ce_n))
    else $error("chip select not from cpu");
  AST_WE_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> write_strobe_n == $past(pin_s[PW-1]))
    else $error("write strobe not from pin");
  AST_OE_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> output_strobe_n == $past(pin_s[PW-2]))
    else $error("output strobe not from pin");
  AST_CE_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> chip_select_n == $past(pin_s[PW-3]))
    else $error("chip select not from pin");
  AST_WIDTH_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> width_select_n == $past(pin_s[PW-4]))
    else $error("width select not from pin");
  AST_FRST_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> flash_reset_n == $past(pin_s[PW-5]))
    else $error("flash reset not from pin");
  AST_ADDR_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> flash_addr == $past(p_addr))
    else $error("address not from pins");
  AST_DATA_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> flash_wdata == $past(p_dq))
    else $error("data not from pins");
  AST_RB_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> pin_ready_busy_oe && pin_ready_busy_n == $past(ready_busy_n))
    else $error("ready busy not on pin");
  AST_CPU_QUIET_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> !cpu_ready && cpu_rdata == '0)
    else $error("cpu sees flash in programming mode");
  AST_DQ_READ_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog && pin_read_req(pin_s) |=> pin_dq_oe)
    else $error("data pins not driven on read");
  AST_DQ_DATA_PROG: assert property (
    @(posedge clk) disable iff (rst)
    prog |=> pin_dq_out == $past(flash_rdata))
    else $error("read data not on pins");
  AST_STRAP_TIME: assert property (
    @(posedge clk) disable iff (rst)
    $rose(strap_seen_reg) |-> prog == ($past(mode_s) == `FPM_MODE_PROG))
    else $error("mode not taken from strap");
  AST_MODE_FIXED: assert property (
    @(posedge clk) disable iff (rst)
    strap_seen_reg |=> $stable(mode_reg))
    else $error("mode changed without reset");
  AST_NO_DRIVE_CPU: assert property (
    @(posedge clk) disable iff (rst)
    !prog |=> !pin_dq_oe)
    else $error("pins driven in cpu mode");
endmodule : fpm_top
